// [logic/dics_regs.sv]
// Config/status register slice of a dual analog/digital display receiver, APB slave
//
// Function
// - Coast config bit 1 is coast polarity: 0 active low, 1 active high, resets 1.
// - Coast polarity applies only with coast disabled and polarity override bit set.
// - 8-bit precoast count of edges filtered before Vsync, resets zero.
// - 8-bit postcoast count of edges filtered after Vsync, resets zero.
// - Output drive bits 7-6: 1x high, 01 medium, 00 low; default 11.
// - Output control bit 5 picks analog bandwidth: 0 is 10 MHz, 1 is 300 MHz.
// - Bit 4 inverts output data clock, digital interface only; default not inverted.
// - Bit 3 set three-states data, line sync, frame sync and pixel valid outputs.
// - Bit 2 drives the protection slave port address bit directly; default 0.
// - Bit 1 written 0 powers chip down; 1 normal; resets 1.
// - Bit 0 picks output format: 0 is 4:4:4, 1 is 4:2:2 on 16 lines.
// - In 4:2:2, green carries luma, red chroma, blue outputs three-stated.
// - Status bit 7 shows Hsync pin activity; stuck level means none.
// - Status bit 6 shows activity on green embedded sync input.
// - Status bit 5 shows Vsync pin activity; stuck level means none.
// - Status bit 4 shows activity on the digital interface clock.
// - Analog present is OR of status bits 7-5; digital present is bit 4.
// - Active flag: digital-only 1, analog-only 0, both uses priority, neither seeks.
// - Interface override forces the active flag to the priority select bit.
// - Active flag 0 means analog interface, 1 means digital interface.
// - Priority select: 0 analog, 1 digital; default 0.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dics_regs
    import dics_pkg::*;
#(
    parameter int ACT_WINDOW = ACT_WINDOW_CYC
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              hsync_in,
    input  wire logic              green_embedded_sync,
    input  wire logic              vsync_in,
    input  wire logic              dig_clk_in,
    output logic                   coast_enable,
    output logic                   coast_pol_user,
    output logic                   coast_polarity,
    output logic      [7:0]        precoast_edges,
    output logic      [7:0]        postcoast_edges,
    output logic      [1:0]        drive_strength,
    output logic                   bw_wide,
    output logic                   out_clk_invert,
    output logic                   red_out_hiz,
    output logic                   green_out_hiz,
    output logic                   blue_out_hiz,
    output logic                   sync_out_hiz,
    output logic                   prot_addr_bit,
    output logic                   chip_sleep_n,
    output logic                   format_422,
    output logic                   soft_seek,
    output logic                   active_interface_flag
);
    // Register storage
    logic [7:0] iface_cfg_r;
    logic [7:0] coast_cfg_r;
    logic [7:0] precoast_r;
    logic [7:0] postcoast_r;
    logic [7:0] out_ctrl_r;
    logic       ai_r;
    logic       ai_nxt;
    logic [N_DET-1:0] det_act;
    logic [N_DET-1:0] det_pins;
    dics_if_state_t   if_sel;

    // One detector per monitored pin: {hsync, sog, vsync, digital clock}
    assign det_pins = {hsync_in, green_embedded_sync, vsync_in, dig_clk_in};

    genvar gi;
    generate
        for (gi = 0; gi < N_DET; gi++) begin : g_det
            dics_activity_det #(
                .WINDOW (ACT_WINDOW)
            ) u_det (
                .pclk    (pclk),
                .presetn (presetn),
                .pin_in  (det_pins[gi]),
                .active  (det_act[gi])
            );
        end
    endgenerate

    // APB decode; the slave answers in the access cycle with no wait states
    wire              acc      = psel & penable;
    wire [ADDR_W-3:0] word     = paddr[ADDR_W-1:2];
    wire              aligned  = (paddr[1:0] == 2'h0);
    wire              hit_if   = aligned && (word == IDX_IFACE_CFG);
    wire              hit_cst  = aligned && (word == IDX_COAST_CFG);
    wire              hit_pre  = aligned && (word == IDX_PRECOAST);
    wire              hit_post = aligned && (word == IDX_POSTCOAST);
    wire              hit_out  = aligned && (word == IDX_OUT_CTRL);
    wire              hit_st   = aligned && (word == IDX_DET_STATUS);
    wire              mapped   = hit_if | hit_cst | hit_pre | hit_post | hit_out | hit_st;
    wire              wr_lane0 = acc & pwrite & pstrb[0];
    // Status is read-only: writes there are accepted but change nothing
    wire              wr_if    = wr_lane0 & hit_if;
    wire              wr_cst   = wr_lane0 & hit_cst;
    wire              wr_pre   = wr_lane0 & hit_pre;
    wire              wr_post  = wr_lane0 & hit_post;

    // Interface presence
    wire analog_seen  = det_act[3] | det_act[2] | det_act[1];
    wire digital_seen = det_act[0];
    wire prio_digital = iface_cfg_r[IF_PRIO_BIT];
    wire if_override  = iface_cfg_r[IF_OVR_BIT];

    // Active interface decision; seek holds the last flag value
    always_comb begin
        if (if_override) begin
            if_sel = prio_digital ? DICS_IF_DIGITAL : DICS_IF_ANALOG;
        end else if (analog_seen && digital_seen) begin
            if_sel = prio_digital ? DICS_IF_DIGITAL : DICS_IF_ANALOG;
        end else if (digital_seen) begin
            if_sel = DICS_IF_DIGITAL;
        end else if (analog_seen) begin
            if_sel = DICS_IF_ANALOG;
        end else begin
            if_sel = DICS_IF_SEEK;
        end
    end

    // Flag encoding: 0 analog, 1 digital
    always_comb begin
        case (if_sel)
            DICS_IF_ANALOG:  ai_nxt = 1'b0;
            DICS_IF_DIGITAL: ai_nxt = 1'b1;
            DICS_IF_SEEK:    ai_nxt = ai_r;
            default:         ai_nxt = ai_r;
        endcase
    end

    wire [7:0] status_val = {det_act[3], det_act[2], det_act[1], det_act[0], ai_r, 3'h0};

    // Read mux; unmapped addresses read zero
    wire [7:0] rd_byte = hit_if   ? iface_cfg_r :
                         hit_cst  ? coast_cfg_r :
                         hit_pre  ? precoast_r  :
                         hit_post ? postcoast_r :
                         hit_out  ? out_ctrl_r  :
                         hit_st   ? status_val  : 8'h00;

    // Config registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            iface_cfg_r <= RST_IFACE_CFG;
            coast_cfg_r <= RST_COAST_CFG;
            precoast_r  <= RST_PRECOAST;
            postcoast_r <= RST_POSTCOAST;
        end else begin
            if (wr_if) iface_cfg_r <= pwdata[7:0];
            if (wr_cst) coast_cfg_r <= pwdata[7:0];
            if (wr_pre) precoast_r <= pwdata[7:0];
            if (wr_post) postcoast_r <= pwdata[7:0];
        end
    end

    // Output control register lives alone: its power-up value differs from zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_ctrl_r <= RST_OUT_CTRL;
        end else if (wr_lane0 & hit_out) begin
            out_ctrl_r <= pwdata[7:0];
        end
    end

    // Active flag, updated every cycle from the detectors
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ai_r      <= 1'b0;
            soft_seek <= 1'b0;
        end else begin
            ai_r      <= ai_nxt;
            soft_seek <= (if_sel == DICS_IF_SEEK);
        end
    end

    // APB answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            if (psel & ~penable & ~pwrite) begin
                prdata <= {24'h00_0000, rd_byte};
            end
        end
    end

    // Control outputs derived from registers; each output is a flop
    wire       cst_en   = coast_cfg_r[COAST_EN_BIT];
    wire       cst_ovr  = coast_cfg_r[COAST_OVR_BIT];
    wire       user_pol = ~cst_en & cst_ovr;
    wire [1:0] drv      = out_ctrl_r[DRIVE_HI_BIT] ? DRIVE_HIGH :
                          out_ctrl_r[DRIVE_LO_BIT] ? DRIVE_MED  : DRIVE_LOW;
    wire       hiz      = out_ctrl_r[HIZ_BIT];
    wire       fmt      = out_ctrl_r[FMT422_BIT];
    wire       dig_act  = ai_nxt;
    wire [7:0] cfg_out  = out_ctrl_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coast_enable    <= 1'b1;
            coast_pol_user  <= 1'b0;
            coast_polarity  <= 1'b1;
            precoast_edges  <= RST_PRECOAST;
            postcoast_edges <= RST_POSTCOAST;
            drive_strength  <= DRIVE_HIGH;
            bw_wide         <= 1'b1;
            out_clk_invert  <= 1'b0;
            red_out_hiz     <= 1'b0;
            green_out_hiz   <= 1'b0;
            blue_out_hiz    <= 1'b0;
            sync_out_hiz    <= 1'b0;
            prot_addr_bit   <= 1'b0;
            chip_sleep_n    <= 1'b1;
            format_422      <= 1'b0;
            active_interface_flag <= 1'b0;
        end else begin
            coast_enable    <= cst_en;
            coast_pol_user  <= user_pol;
            coast_polarity  <= coast_cfg_r[COAST_POL_BIT];
            precoast_edges  <= precoast_r;
            postcoast_edges <= postcoast_r;
            drive_strength  <= drv;
            bw_wide         <= cfg_out[BW_BIT];
            out_clk_invert  <= cfg_out[CLK_INV_BIT] & dig_act;
            red_out_hiz     <= hiz;
            green_out_hiz   <= hiz;
            blue_out_hiz    <= hiz | fmt;
            sync_out_hiz    <= hiz;
            prot_addr_bit   <= cfg_out[PROT_ADDR_BIT];
            chip_sleep_n    <= cfg_out[SLEEP_N_BIT];
            format_422      <= fmt;
            active_interface_flag <= ai_nxt;
        end
    end
endmodule : dics_regs
`default_nettype wire

// [logic/dics_pkg.sv]
// Package: register map, field positions, reset values and detector timing for the display config/status block
package dics_pkg;
    // Register word indices (printed offsets are not word aligned, so byte address is index * 4)
    localparam logic [7:0] IDX_IFACE_CFG  = 8'h0f;
    localparam logic [7:0] IDX_COAST_CFG  = 8'h11;
    localparam logic [7:0] IDX_PRECOAST   = 8'h12;
    localparam logic [7:0] IDX_POSTCOAST  = 8'h13;
    localparam logic [7:0] IDX_OUT_CTRL   = 8'h14;
    localparam logic [7:0] IDX_DET_STATUS = 8'h15;
    localparam int         ADDR_W         = 10;

    // Coast config fields
    localparam int COAST_POL_BIT   = 1;
    localparam int COAST_OVR_BIT   = 2;
    localparam int COAST_EN_BIT    = 3;
    // Interface config fields
    localparam int IF_PRIO_BIT     = 1;
    localparam int IF_OVR_BIT      = 2;
    // Output control fields
    localparam int DRIVE_HI_BIT    = 7;
    localparam int DRIVE_LO_BIT    = 6;
    localparam int BW_BIT          = 5;
    localparam int CLK_INV_BIT     = 4;
    localparam int HIZ_BIT         = 3;
    localparam int PROT_ADDR_BIT   = 2;
    localparam int SLEEP_N_BIT     = 1;
    localparam int FMT422_BIT      = 0;
    // Status fields
    localparam int ST_HSYNC_BIT    = 7;
    localparam int ST_SOG_BIT      = 6;
    localparam int ST_VSYNC_BIT    = 5;
    localparam int ST_DCLK_BIT     = 4;
    localparam int ST_AI_BIT       = 3;

    // Reset values
    localparam logic [7:0] RST_IFACE_CFG = 8'h00;
    localparam logic [7:0] RST_COAST_CFG = 8'h0a;
    localparam logic [7:0] RST_PRECOAST  = 8'h00;
    localparam logic [7:0] RST_POSTCOAST = 8'h00;
    localparam logic [7:0] RST_OUT_CTRL  = 8'hc2;

    // Drive strength codes
    localparam logic [1:0] DRIVE_LOW  = 2'h0;
    localparam logic [1:0] DRIVE_MED  = 2'h1;
    localparam logic [1:0] DRIVE_HIGH = 2'h2;

    // Activity window: a pin with no edge for this long reads as idle
    localparam int ACT_WINDOW_US  = 100;
    localparam int CLK_MHZ        = 100;
    localparam int ACT_WINDOW_CYC = ACT_WINDOW_US * CLK_MHZ;
    localparam int ACT_CNT_W      = 16;
    localparam int N_DET          = 4;

    typedef enum logic [1:0] {
        DICS_IF_ANALOG,
        DICS_IF_DIGITAL,
        DICS_IF_SEEK
    } dics_if_state_t;
endpackage : dics_pkg

// [logic/dics_activity_det.sv]
// Activity detector: reports whether an input pin toggled within the recent window
`timescale 1ns/1ps
`default_nettype none
module dics_activity_det
    import dics_pkg::*;
#(
    parameter int WINDOW = ACT_WINDOW_CYC
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin_in,
    output logic      active
);
    logic                 prev_r;
    logic [ACT_CNT_W-1:0] cnt_r;
    logic                 edge_seen;

    // Any change of level counts; a pin stuck low never does, one stuck high counts once after reset
    assign edge_seen = pin_in ^ prev_r;

    // Window counter restarts on every edge and saturates at the window end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_r <= 1'b0;
            cnt_r  <= '0;
            active <= 1'b0;
        end else begin
            prev_r <= pin_in;
            if (edge_seen) begin
                cnt_r  <= ACT_CNT_W'(WINDOW);
                active <= 1'b1;
            end else if (cnt_r != '0) begin
                cnt_r  <= cnt_r - 1'b1;
            end else begin
                active <= 1'b0;
            end
        end
    end
endmodule : dics_activity_det
`default_nettype wire

// [dv/dics_regs_monitor.sv]
// Checker for the display config/status register slice
`timescale 1ns/1ps
`default_nettype none
module dics_regs_monitor
    import dics_pkg::*;
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              coast_pol_user,
    input wire logic              coast_polarity,
    input wire logic [7:0]        precoast_edges,
    input wire logic [1:0]        drive_strength,
    input wire logic              bw_wide,
    input wire logic              out_clk_invert,
    input wire logic              blue_out_hiz,
    input wire logic              sync_out_hiz,
    input wire logic              prot_addr_bit,
    input wire logic              chip_sleep_n,
    input wire logic              format_422,
    input wire logic              active_interface_flag
);
    // Completed transfers, decoded per register
    wire       done   = psel && penable && pready;
    wire       acc    = done && pwrite && pstrb[0];
    wire       wr_out = acc && paddr == 10'h50;
    wire       wr_cst = acc && paddr == 10'h44;
    wire       wr_pre = acc && paddr == 10'h48;
    wire       mapped = paddr inside {10'h3c, 10'h44, 10'h48, 10'h4c, 10'h50, 10'h54};
    logic [7:0] wd_r;

    // Written byte kept so outputs can be compared two edges later
    always_ff @(posedge pclk) begin
        if (acc) wd_r <= pwdata[7:0];
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_drive_code: assert property (wr_out |=> ##1 drive_strength == (wd_r[7] ? 2'h2 : {1'b0, wd_r[6]}))
        else $error("drive strength wrong");
    chk_band_sel: assert property (wr_out |=> ##1 bw_wide == wd_r[5])
        else $error("bandwidth select wrong");
    chk_hiz_follow: assert property (wr_out |=> ##1 sync_out_hiz == wd_r[3])
        else $error("three-state control wrong");
    chk_prot_addr: assert property (wr_out |=> ##1 prot_addr_bit == wd_r[2])
        else $error("protection address bit wrong");
    chk_sleep_bit: assert property (wr_out |=> ##1 chip_sleep_n == wd_r[1])
        else $error("sleep control wrong");
    chk_format_sel: assert property (wr_out |=> ##1 format_422 == wd_r[0])
        else $error("output format wrong");
    chk_blue_hiz: assert property (blue_out_hiz == (sync_out_hiz || format_422))
        else $error("blue three-state wrong");
    chk_coast_pol: assert property (wr_cst |=> ##1 coast_polarity == wd_r[1] && coast_pol_user == (!wd_r[3] && wd_r[2]))
        else $error("coast polarity wrong");
    chk_pre_count: assert property (wr_pre |=> ##1 precoast_edges == wd_r)
        else $error("precoast count wrong");
    chk_clk_inv: assert property (out_clk_invert |-> active_interface_flag || $past(active_interface_flag))
        else $error("clock invert outside digital interface");
    chk_bad_addr: assert property (done && !mapped |-> pslverr)
        else $error("unmapped access not refused");
    chk_ro_status: assert property (done && paddr == 10'h54 |-> !pslverr)
        else $error("status access refused");

    // Main scenarios reached
    cov_out_write: cover property (wr_out);
    cov_coast_write: cover property (wr_cst);
    cov_refused: cover property (done && pslverr);
endmodule : dics_regs_monitor
`default_nettype wire

// [dv/dics_regs_test.sv]
// Self-checking bench for the display config/status register slice
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin fail_count++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module dics_regs_test;
    import dics_pkg::*;
    localparam int ACT = 8;
    logic        pclk, presetn, psel, penable, pwrite, rd_err, flag_e;
    logic [9:0]  paddr;
    logic [31:0] pwdata, prdata, seed, rd;
    logic [3:0]  pstrb, tog, pins;
    logic        pready, pslverr, coast_enable, coast_pol_user, coast_polarity, bw_wide, out_clk_invert;
    logic        red_out_hiz, green_out_hiz, blue_out_hiz, sync_out_hiz, prot_addr_bit;
    logic        chip_sleep_n, format_422, soft_seek, active_interface_flag;
    logic [7:0]  precoast_edges, postcoast_edges, outv, ifv, pre_v, cst_v;
    logic [1:0]  drive_strength;
    int          fail_count, total_checks;
    logic [9:0]  addrs [6] = '{10'h3c, 10'h44, 10'h48, 10'h4c, 10'h50, 10'h54};
    logic [7:0]  rstv [6] = '{8'h00, 8'h0a, 8'h00, 8'h00, 8'hc2, 8'h00};
    logic [7:0]  corner [4] = '{8'h06, 8'h04, 8'h00, 8'hff}; // First corner is coast off with override and polarity set

    dics_regs #(.ACT_WINDOW(ACT)) i_dics_regs (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .hsync_in(pins[3]), .green_embedded_sync(pins[2]), .vsync_in(pins[1]), .dig_clk_in(pins[0]),
        .coast_enable(coast_enable), .coast_pol_user(coast_pol_user), .coast_polarity(coast_polarity),
        .precoast_edges(precoast_edges), .postcoast_edges(postcoast_edges), .drive_strength(drive_strength),
        .bw_wide(bw_wide), .out_clk_invert(out_clk_invert), .red_out_hiz(red_out_hiz),
        .green_out_hiz(green_out_hiz), .blue_out_hiz(blue_out_hiz), .sync_out_hiz(sync_out_hiz),
        .prot_addr_bit(prot_addr_bit), .chip_sleep_n(chip_sleep_n), .format_422(format_422),
        .soft_seek(soft_seek), .active_interface_flag(active_interface_flag));

    // Clock, and monitored pins that toggle each cycle while enabled
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) pins <= pins ^ tog;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic exp_flag(input logic [3:0] t, input logic ovr, input logic prio, input logic prev);
        if (ovr || (|t[3:1] && t[0])) return prio;
        if (t[0] || |t[3:1]) return t[0];
        return prev; // Seek mode keeps the last choice
    endfunction : exp_flag

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict

    // One APB transfer; the wait for pready is bounded so a hang ends the run
    task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            fail_count++;
            print_verdict();
        end
    endtask : apb

    // Write a register, read it back; outputs have settled by the read's end
    task automatic put(input logic [9:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
        apb(1'b0, a, 32'h0);
        `CHK("readback", {24'h0, d}, rd)
    endtask : put

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pins, tog, fail_count, total_checks} = '0;
        pstrb = 4'hf;
        seed = 32'h70b5;
        flag_e = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, addrs[i], 32'h0);
            `CHK("reset value", {24'h0, rstv[i]}, rd)
        end
        // Output control: corners then random bytes
        for (int i = 0; i < 14; i++) begin
            seed = lfsr(seed);
            outv = (i < 4) ? {corner[i][7:6] ^ 2'h1, corner[i][5:0]} : seed[7:0];
            put(10'h50, outv);
            `CHK("drive", (outv[7] ? 2'h2 : {1'b0, outv[6]}), drive_strength)
            `CHK("bandwidth", outv[5], bw_wide)
            `CHK("hiz", {4{outv[3]}} | {1'b0, outv[0], 2'b0}, {red_out_hiz, blue_out_hiz, green_out_hiz, sync_out_hiz})
            `CHK("prot addr", outv[2], prot_addr_bit)
            `CHK("sleep", outv[1], chip_sleep_n)
            `CHK("format", outv[0], format_422)
        end
        // Coast configuration and the two edge counts
        for (int i = 0; i < 10; i++) begin
            seed = lfsr(seed);
            cst_v = (i < 4) ? corner[i] : seed[7:0];
            put(10'h44, cst_v);
            `CHK("coast", {cst_v[3], cst_v[1], !cst_v[3] && cst_v[2]}, {coast_enable, coast_polarity, coast_pol_user})
            pre_v = seed[15:8];
            put(10'h48, pre_v);
            `CHK("precoast", pre_v, precoast_edges)
            put(10'h4c, seed[23:16]);
            `CHK("postcoast", seed[23:16], postcoast_edges)
        end
        // A write without lane 0 strobe is dropped
        pstrb <= 4'he;
        apb(1'b1, 10'h48, ~{24'h0, pre_v});
        pstrb <= 4'hf;
        apb(1'b0, 10'h48, 32'h0);
        `CHK("masked write", {24'h0, pre_v}, rd)
        outv = 8'hd2;
        put(10'h50, outv);
        // Every pin activity combination, then random override and priority
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            ifv = {5'h0, (i > 15) && seed[5], seed[4], 1'b0};
            put(10'h3c, ifv);
            // New priority acts on the old pins first; seek then holds that choice
            flag_e = exp_flag(tog, ifv[2], ifv[1], flag_e);
            tog <= (i < 16) ? i[3:0] : seed[3:0];
            repeat (ACT + 4) @(posedge pclk);
            flag_e = exp_flag(tog, ifv[2], ifv[1], flag_e);
            apb(1'b0, 10'h54, 32'h0);
            `CHK("status", {24'h0, tog, flag_e, 3'h0}, rd)
            `CHK("active flag", flag_e, active_interface_flag)
            `CHK("seek", tog == 4'h0 && !ifv[2], soft_seek)
            `CHK("clock invert", outv[4] && flag_e, out_clk_invert)
        end
        // Status ignores writes; unmapped and unaligned addresses are refused
        apb(1'b1, 10'h54, 32'hff);
        `CHK("status write err", 1'b0, rd_err)
        apb(1'b0, 10'h54, 32'h0);
        `CHK("status after write", {24'h0, tog, flag_e, 3'h0}, rd)
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, i ? 10'h51 : 10'h3f0, 32'hff);
            apb(1'b0, i ? 10'h51 : 10'h3f0, 32'h0);
            `CHK("refused", 33'h100000000, {rd_err, rd})
        end
        `CHK("refused write", outv[5], bw_wide)
        print_verdict();
    end
endmodule : dics_regs_test

bind dics_regs dics_regs_monitor i_dics_regs_monitor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .coast_pol_user(coast_pol_user),
    .coast_polarity(coast_polarity), .precoast_edges(precoast_edges), .drive_strength(drive_strength),
    .bw_wide(bw_wide), .out_clk_invert(out_clk_invert), .blue_out_hiz(blue_out_hiz),
    .sync_out_hiz(sync_out_hiz), .prot_addr_bit(prot_addr_bit), .chip_sleep_n(chip_sleep_n),
    .format_422(format_422), .active_interface_flag(active_interface_flag));
`default_nettype wire
